// >>> core/dio_cfg.svh
// Offsets, field positions, group counts and widths of the digital I/O block.
// Assumes inclusion by bare name from the core folder.
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH
`define DIO_OFF_CTRL 12'h000
`define DIO_OFF_DIR 12'h004
`define DIO_OFF_BIDIR 12'h008
`define DIO_OFF_DIN 12'h00C
`define DIO_OFF_DOUT 12'h010
`define DIO_OFF_IRQINV 12'h014
`define DIO_OFF_IRQSTAT 12'h018
`define DIO_CTRL_ENABLE 0
`define DIO_CTRL_IRQEN 1
`define DIO_GROUPS 3
`define DIO_GROUP_W 8
`define DIO_IN_W 16
`define DIO_OUT_W 16
`define DIO_IRQ_N 4
`define DIO_IRQ_GROUP 2
`endif

// >>> core/dio_pkg.sv
// Types shared by the digital I/O block.
// Assumes the cfg header is on the include path.
`include "dio_cfg.svh"
package dio_pkg;
  // ************************************
  // Bus carriers
  // ************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dio_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dio_apb_rsp_t;
  typedef struct packed {
    logic [`DIO_GROUPS*`DIO_GROUP_W-1:0] out;
    logic [`DIO_GROUPS*`DIO_GROUP_W-1:0] oe;
  } dio_bidir_drv_t;
endpackage

// >>> core/dio_port.sv
// Digital I/O port: 24-line bidirectional port, 16-bit input, 16-bit output, irq.
// Assumes an APB master on sys_clk and synchronous field inputs.
//
// The APB register port and the address map were decided locally.
`include "dio_cfg.svh"
module dio_port #(
  parameter int GROUPS = `DIO_GROUPS,
  parameter int IN_W = `DIO_IN_W,
  parameter int OUT_W = `DIO_OUT_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire dio_pkg::dio_apb_req_t apbReq,
  output dio_pkg::dio_apb_rsp_t apbRsp,
  input wire logic [GROUPS*8-1:0] bidirIn,
  output dio_pkg::dio_bidir_drv_t bidirDrv,
  input wire logic [IN_W-1:0] dinPins,
  output logic [OUT_W-1:0] doutPins,
  output logic doutOe,
  output logic irqReq
);
  // Package carriers and irq source position fix the bidirectional port at three groups
  if (GROUPS != 3 || IN_W < 1 || IN_W > 32 || OUT_W < 1 || OUT_W > 32) begin : g_param_chk
    $error("dio_port: unsupported parameters");
  end

  localparam int BW = GROUPS * 8;

  // ************************************
  // Register state
  // ************************************
  logic enable_q, enable_d;
  logic irqEn_q, irqEn_d;
  logic [GROUPS-1:0] dir_q, dir_d;
  logic [BW-1:0] bidirLatch_q, bidirLatch_d;
  logic [OUT_W-1:0] doutLatch_q, doutLatch_d;
  logic [3:0] irqInv_q, irqInv_d;
  logic [31:0] rdata_q, rdata_d;

  logic [BW-1:0] oeVec;
  logic [BW-1:0] bidirView;
  logic [3:0] irqSrc;
  logic [3:0] irqLvl;
  logic wrEn;
  logic rdEn;
  logic mapped;

  // ************************************
  // Port behaviour
  // ************************************
  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      oeVec[g*8 +: 8] = {8{dir_q[g] & enable_q}};
    end
    for (int i = 0; i < BW; i++) begin
      bidirView[i] = oeVec[i] ? bidirLatch_q[i] : bidirIn[i];
    end
  end

  assign bidirDrv.out = bidirLatch_q & oeVec;
  assign bidirDrv.oe = oeVec;
  assign doutPins = enable_q ? doutLatch_q : '0;
  assign doutOe = enable_q;

  // Irq sources taken from raw pins so status is visible before direction set
  assign irqSrc = bidirIn[`DIO_IRQ_GROUP*8 +: `DIO_IRQ_N];
  assign irqLvl = irqSrc ^ irqInv_q;
  assign irqReq = irqEn_q & enable_q & (|irqLvl);

  // ************************************
  // APB slave, zero wait states
  // ************************************
  assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign rdEn = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;

  always_comb begin
    mapped = 1'b1;
    if (apbReq.paddr == `DIO_OFF_CTRL) begin
      mapped = 1'b1;
    end else if (apbReq.paddr == `DIO_OFF_DIR) begin
      mapped = 1'b1;
    end else if (apbReq.paddr == `DIO_OFF_BIDIR) begin
      mapped = 1'b1;
    end else if (apbReq.paddr == `DIO_OFF_DIN) begin
      mapped = 1'b1;
    end else if (apbReq.paddr == `DIO_OFF_DOUT) begin
      mapped = 1'b1;
    end else if (apbReq.paddr == `DIO_OFF_IRQINV) begin
      mapped = 1'b1;
    end else if (apbReq.paddr == `DIO_OFF_IRQSTAT) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = apbReq.psel & apbReq.penable & ~mapped;
  assign apbRsp.prdata = rdata_q;

  always_comb begin
    enable_d = enable_q;
    irqEn_d = irqEn_q;
    dir_d = dir_q;
    bidirLatch_d = bidirLatch_q;
    doutLatch_d = doutLatch_q;
    irqInv_d = irqInv_q;
    rdata_d = rdata_q;
    if (wrEn) begin
      if (apbReq.paddr == `DIO_OFF_CTRL) begin
        enable_d = apbReq.pwdata[`DIO_CTRL_ENABLE];
        irqEn_d = apbReq.pwdata[`DIO_CTRL_IRQEN];
      end else if (apbReq.paddr == `DIO_OFF_DIR) begin
        dir_d = apbReq.pwdata[GROUPS-1:0];
      end else if (apbReq.paddr == `DIO_OFF_BIDIR) begin
        bidirLatch_d = apbReq.pwdata[BW-1:0];
      end else if (apbReq.paddr == `DIO_OFF_DOUT) begin
        doutLatch_d = apbReq.pwdata[OUT_W-1:0];
      end else if (apbReq.paddr == `DIO_OFF_IRQINV) begin
        irqInv_d = apbReq.pwdata[3:0];
      end
    end
    if (rdEn) begin
      rdata_d = 32'h0000_0000;
      if (apbReq.paddr == `DIO_OFF_CTRL) begin
        rdata_d[`DIO_CTRL_ENABLE] = enable_q;
        rdata_d[`DIO_CTRL_IRQEN] = irqEn_q;
      end else if (apbReq.paddr == `DIO_OFF_DIR) begin
        rdata_d[GROUPS-1:0] = dir_q;
      end else if (apbReq.paddr == `DIO_OFF_BIDIR) begin
        // Disabled port reads zero rather than floating pins
        rdata_d[BW-1:0] = enable_q ? bidirView : '0;
      end else if (apbReq.paddr == `DIO_OFF_DIN) begin
        rdata_d[IN_W-1:0] = enable_q ? dinPins : '0;
      end else if (apbReq.paddr == `DIO_OFF_DOUT) begin
        rdata_d[OUT_W-1:0] = doutLatch_q;
      end else if (apbReq.paddr == `DIO_OFF_IRQINV) begin
        rdata_d[3:0] = irqInv_q;
      end else if (apbReq.paddr == `DIO_OFF_IRQSTAT) begin
        rdata_d[3:0] = irqSrc;
        rdata_d[7:4] = irqLvl;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      enable_q <= 1'b0;
      irqEn_q <= 1'b0;
      dir_q <= '0;
      bidirLatch_q <= '0;
      doutLatch_q <= '0;
      irqInv_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
    end else if (clkEn) begin
      enable_q <= enable_d;
      irqEn_q <= irqEn_d;
      dir_q <= dir_d;
      bidirLatch_q <= bidirLatch_d;
      doutLatch_q <= doutLatch_d;
      irqInv_q <= irqInv_d;
      rdata_q <= rdata_d;
    end
  end
endmodule

// >>> verification/dio_field_model.sv
// Field side of the bidirectional connector.
// Assumes the bench supplies the external source levels.
module dio_field_model (
  input wire dio_pkg::dio_bidir_drv_t drv,
  input wire logic [23:0] ext,
  output logic [23:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Wire resolution: port wins where it drives
  // ****
  assign lines = (drv.out & drv.oe) | (ext & ~drv.oe);
endmodule

// >>> verification/dio_port_assertions.sv
// Checker bound to the digital I/O port pins.
// Assumes one clock, sync active-low reset; writes count only with clkEn high.
module dio_port_assertions #(parameter int GROUPS = 3, parameter int IN_W = 16,
  parameter int OUT_W = 16) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire dio_pkg::dio_apb_req_t apbReq,
  input wire dio_pkg::dio_apb_rsp_t apbRsp,
  input wire logic [GROUPS*8-1:0] bidirIn,
  input wire dio_pkg::dio_bidir_drv_t bidirDrv,
  input wire logic [IN_W-1:0] dinPins,
  input wire logic [OUT_W-1:0] doutPins,
  input wire logic doutOe,
  input wire logic irqReq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Pin checks
  // ****
  logic wr;
  assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite && clkEn;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  out_gated_a: assert property ((bidirDrv.out & ~bidirDrv.oe) == 24'h0)
    else $error("undriven line shows data");
  oe_group_a: assert property (bidirDrv.oe == {{8{bidirDrv.oe[16]}},
    {8{bidirDrv.oe[8]}}, {8{bidirDrv.oe[0]}}}) else $error("group enable split");
  dout_off_a: assert property (!doutOe |-> doutPins == 16'h0)
    else $error("output port drives while off");
  rst_clear_a: assert property (disable iff (1'b0) !reset_n |=>
    bidirDrv.oe == 24'h0 && !doutOe && !irqReq) else $error("reset leaves drive");
  irq_gate_a: assert property (irqReq |-> doutOe)
    else $error("irq while disabled");
  irq_cause_a: assert property (!$stable(irqReq) |-> !$stable(bidirIn[19:16])
    || $past(wr) || !$past(reset_n)) else $error("irq moved without cause");
  oe_cause_a: assert property (!$stable(bidirDrv.oe) |-> $past(wr)
    || !$past(reset_n)) else $error("direction moved without write");
  dout_cause_a: assert property (!$stable({doutOe, doutPins}) |-> $past(wr)
    || !$past(reset_n)) else $error("output port moved without write");
endmodule
bind dio_port dio_port_assertions #(.GROUPS(GROUPS), .IN_W(IN_W), .OUT_W(OUT_W)) chk (.sys_clk,
  .reset_n, .clkEn, .apbReq, .apbRsp, .bidirIn, .bidirDrv, .dinPins, .doutPins, .doutOe, .irqReq);

// >>> verification/dio_port_test.sv
// Self-checking bench for the digital I/O port.
// Assumes the cfg header on the include path.
`include "dio_cfg.svh"
module dio_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench
  // ****
  logic sys_clk = 0;
  logic reset_n = 0;
  dio_pkg::dio_apb_req_t apbReq = '0;
  dio_pkg::dio_apb_rsp_t apbRsp;
  dio_pkg::dio_bidir_drv_t bidirDrv;
  logic [23:0] bidirIn, v, ext = 24'h0;
  logic [15:0] doutPins, dinPins = 16'h0;
  logic doutOe, irqReq;
  logic [31:0] q;
  logic [2:0] m;
  logic e;
  logic clkEn = 1'b1;
  int n_errors = 0, comparisons = 0;
  dio_port dut (.sys_clk, .reset_n, .clkEn, .apbReq, .apbRsp, .bidirIn, .bidirDrv,
    .dinPins, .doutPins, .doutOe, .irqReq);
  dio_field_model field (.drv(bidirDrv), .ext(ext), .lines(bidirIn));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle at the end keeps back-to-back calls off one time step
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= w;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    @(posedge sys_clk);
    while (apbRsp.pready !== 1'b1) @(posedge sys_clk);
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic logic [23:0] mix(input logic [2:0] d, input logic [23:0] l, e);
    for (int g = 0; g < 3; g++) mix[8*g +: 8] = d[g] ? l[8*g +: 8] : e[8*g +: 8];
  endfunction
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(67));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    chk({doutOe, irqReq, bidirDrv.oe}, 32'h0);
    bus(1'b0, `DIO_OFF_DIN, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `DIO_OFF_DOUT, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 12'h01C, 32'h0);
    chk({q[30:0], e}, 32'h1);
    $display("test reset done");
    bus(1'b1, `DIO_OFF_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      ext <= $urandom;
      dinPins <= $urandom;
      m = (i == 0) ? 3'h0 : (i == 5) ? 3'h7 : 3'($urandom);
      bus(1'b1, `DIO_OFF_DIR, 32'h0);
      bus(1'b1, `DIO_OFF_BIDIR, {8'h0, v});
      chk(bidirDrv.oe, 32'h0);
      bus(1'b1, `DIO_OFF_DOUT, {16'h0, v[15:0]});
      chk(doutPins, v[15:0]);
      bus(1'b0, `DIO_OFF_DIN, 32'h0);
      chk(q, dinPins);
      bus(1'b1, `DIO_OFF_DIR, m);
      chk(bidirDrv.out, mix(m, v, 24'h0));
      bus(1'b0, `DIO_OFF_BIDIR, 32'h0);
      chk(q, mix(m, v, ext));
    end
    $display("test ports done");
    bus(1'b1, `DIO_OFF_CTRL, 32'h0);
    chk({doutPins, bidirDrv.oe[15:0]}, 32'h0);
    bus(1'b0, `DIO_OFF_BIDIR, 32'h0);
    chk(q, 32'h0);
    $display("test disable done");
    bus(1'b1, `DIO_OFF_DIR, 32'h0);
    for (int i = 0; i < 16; i++) begin
      ext <= $urandom;
      bus(1'b1, `DIO_OFF_CTRL, 32'h1);
      bus(1'b1, `DIO_OFF_IRQINV, i);
      chk(irqReq, 1'b0);
      bus(1'b1, `DIO_OFF_CTRL, 32'h3);
      chk(irqReq, |(ext[19:16] ^ 4'(i)));
      bus(1'b0, `DIO_OFF_IRQSTAT, 32'h0);
      chk(q, {ext[19:16] ^ 4'(i), ext[19:16]});
      bus(1'b1, `DIO_OFF_IRQINV, ext[19:16]);
      chk(irqReq, 1'b0);
    end
    bus(1'b1, `DIO_OFF_IRQINV, ~ext[19:16]);
    bus(1'b1, `DIO_OFF_CTRL, 32'h2);
    chk(irqReq, 1'b0);
    $display("test irq done");
    // Frozen clock enable must swallow the enable write
    clkEn <= 1'b0;
    bus(1'b1, `DIO_OFF_CTRL, 32'h1);
    clkEn <= 1'b1;
    @(posedge sys_clk);
    chk({doutOe, bidirDrv.oe}, 32'h0);
    $display("test freeze done");
    end_sim();
  end
endmodule
